// file: uart_irq_defs.vh
// constants for the interrupt enable and status block
`ifndef UART_IRQ_DEFS_VH
`define UART_IRQ_DEFS_VH
// ==========================================
// register addresses (a2..a0)
`define ADDR_RECEIVE_HOLDING 3'h0
`define ADDR_INTERRUPT_ENABLE 3'h1
`define ADDR_INTERRUPT_STATUS 3'h2
`define ADDR_LINE_STATUS 3'h5
`define ADDR_MODEM_STATUS 3'h6
`define ENH_ACCESS_CODE 8'hbf
// ==========================================
// enable bit positions
`define IEN_RX_DATA 0
`define IEN_TX_READY 1
`define IEN_LINE 2
`define IEN_MODEM 3
`define IEN_SLEEP 4
`define IEN_XOFF 5
`define IEN_RTS 6
`define IEN_CTS 7
`define IEN_RESET 8'h00
// ==========================================
// status codes, six bits
`define CODE_LINE 6'h06
`define CODE_TIMEOUT 6'h0c
`define CODE_RX_DATA 6'h04
`define CODE_TX_READY 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF 6'h10
`define CODE_FLOW 6'h20
`define CODE_NONE 6'h01
// ==========================================
// time-out: 4 characters plus 12 bit times
`define TMO_CHARS 4
`define TMO_EXTRA_BITS 12
`endif

// file: trigger_level_decode.v
// decode of a two-bit fifo trigger select into a level
`timescale 1ns/100ps
module trigger_level_decode
(
  input wire [1:0] sel,
  output reg [4:0] level
);
  // ==========================================
  // select to level: 1, 4, 8, 14
  always @*
  begin
    case (sel)
      2'h0: level = 5'h01;
      2'h1: level = 5'h04;
      2'h2: level = 5'h08;
      default: level = 5'h0e;
    endcase
  end
endmodule // trigger_level_decode

// file: rx_timeout_timer.v
// receive time-out delay timer counted in bit ticks
`timescale 1ns/100ps
`include "uart_irq_defs.vh"
module rx_timeout_timer
#(
  parameter CNT_W = 8
)
(
  input wire ref_clk,
  input wire reset,
  input wire bit_tick,
  input wire restart,
  input wire armed,
  input wire [3:0] char_bits,
  output wire expired
)
;
  localparam [CNT_W-1:0] EXTRA_BITS = `TMO_EXTRA_BITS;
  reg [CNT_W-1:0] count_ff;
  wire [CNT_W-1:0] limit;
  wire [CNT_W-1:0] nxt_count;
  wire [CNT_W-1:0] char_wide;
  // ==========================================
  // limit of four characters plus twelve bits; CNT_W must hold 4*15+12
  assign char_wide = {{(CNT_W-4){1'b0}}, char_bits};
  assign limit = (char_wide << 2) + EXTRA_BITS;
  assign expired = armed && (count_ff >= limit);
  // restart on any receive activity; hold once expired
  assign nxt_count = (restart || !armed) ? {CNT_W{1'b0}} :
                     (bit_tick && !expired) ? count_ff + 1'b1 : count_ff;
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      count_ff <= {CNT_W{1'b0}};
    else
      count_ff <= nxt_count;
  end
endmodule // rx_timeout_timer

// file: uart_interrupt_enable_status.v
// interrupt enable, line status flags and prioritised interrupt status
`timescale 1ns/100ps
`include "uart_irq_defs.vh"
module uart_interrupt_enable_status
#(
  parameter LEVEL_W = 5
)
(
  input wire ref_clk,
  input wire reset,
  // register port
  input wire [2:0] addr,
  input wire rd_strobe,
  input wire wr_strobe,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data_ff,
  // configuration from neighbouring registers
  input wire [7:0] line_control,
  input wire fifo_enable,
  input wire [1:0] rx_trigger_sel,
  input wire [1:0] tx_trigger_sel,
  input wire enh_enable,
  input wire auto_rts_enable,
  input wire auto_cts_enable,
  // receive side
  input wire [LEVEL_W-1:0] rx_level,
  input wire rx_load,
  input wire rx_overrun_event,
  input wire [2:0] rx_head_errors,
  input wire rx_fifo_has_error,
  input wire bit_tick,
  input wire [3:0] char_bits,
  // transmit side
  input wire [LEVEL_W-1:0] tx_level,
  input wire tx_shift_empty,
  // modem and flow control
  input wire [3:0] modem_delta,
  input wire [3:0] modem_inputs,
  input wire rts_rise,
  input wire cts_rise,
  input wire xoff_detect,
  input wire xon_detect,
  input wire special_detect,
  input wire wake_event,
  // outputs
  output wire sleep_enable,
  output reg irq_ff
);
  reg [7:0] ien_ff;
  reg overrun_ff;
  reg line_err_ff;
  reg tx_ready_ff;
  reg xoff_ff;
  reg special_ff;
  reg flow_ff;
  reg wake_ff;
  reg tx_cond_ff;
  reg [5:0] code_ff;
  reg [5:0] nxt_code;
  reg nxt_pending;
  wire [4:0] rx_trig;
  wire [4:0] tx_trig;
  wire rx_empty;
  wire tx_empty;
  wire enh_regs;
  wire rd_rhr;
  wire rd_isr;
  wire rd_lsr;
  wire rd_msr;
  wire wr_thr;
  wire wr_ien;
  wire rx_data_src;
  wire tmo_src;
  wire line_src;
  wire modem_src;
  wire [7:0] line_status;
  wire tmo_expired;
  wire head_err;
  wire code_busy;
  wire tx_cond;
  wire tx_cond_rise;
  wire tx_en_rise;
  wire tx_ready_set;
  wire tx_src;
  wire xoff_src;
  wire flow_src;
  wire wake_src;
  wire [7:0] status_byte;
  // ==========================================
  // decode of accesses
  assign enh_regs = (line_control == `ENH_ACCESS_CODE);
  assign rd_rhr = rd_strobe && !line_control[7] && (addr == `ADDR_RECEIVE_HOLDING);
  assign rd_isr = rd_strobe && !enh_regs && (addr == `ADDR_INTERRUPT_STATUS);
  assign rd_lsr = rd_strobe && !enh_regs && (addr == `ADDR_LINE_STATUS);
  assign rd_msr = rd_strobe && (addr == `ADDR_MODEM_STATUS);
  assign wr_thr = wr_strobe && !line_control[7] && (addr == `ADDR_RECEIVE_HOLDING);
  assign wr_ien = wr_strobe && !line_control[7] && (addr == `ADDR_INTERRUPT_ENABLE);
  // ==========================================
  // trigger levels
  trigger_level_decode u_rx_trig
  (
    .sel(rx_trigger_sel),
    .level(rx_trig)
  );
  // transmit select only counts with the enhanced bit; level 1 otherwise
  trigger_level_decode u_tx_trig
  (
    .sel(enh_enable ? tx_trigger_sel : 2'h0),
    .level(tx_trig)
  );
  // ==========================================
  // receive time-out timer, armed while data waits in the fifo
  rx_timeout_timer #(.CNT_W(8)) u_tmo
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .bit_tick(bit_tick),
    .restart(rx_load || rd_rhr),
    .armed(fifo_enable && !rx_empty),
    .char_bits(char_bits),
    .expired(tmo_expired)
  );
  assign rx_empty = (rx_level == {LEVEL_W{1'b0}});
  assign tx_empty = (tx_level == {LEVEL_W{1'b0}});
  assign head_err = |rx_head_errors;
  // ==========================================
  // enable register; upper nibble only with enhanced bit
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ien_ff <= `IEN_RESET;
    else if (wr_ien)
      ien_ff <= enh_enable ? wr_data : {ien_ff[7:4], wr_data[3:0]};
  end
  assign sleep_enable = ien_ff[`IEN_SLEEP];
  // ==========================================
  // line status flags, polled mode works with all enables low
  assign line_status = {rx_fifo_has_error,
                        tx_empty && tx_shift_empty,
                        tx_empty,
                        rx_head_errors,
                        overrun_ff,
                        !rx_empty};
  // ==========================================
  // transmit ready condition and its rising edge
  // holding empty in character mode, below the trigger in fifo mode
  assign tx_cond = fifo_enable ? (tx_level < tx_trig) : tx_empty;
  assign tx_cond_rise = tx_cond && !tx_cond_ff;
  // enabling while already empty must interrupt at once
  assign tx_en_rise = wr_ien && wr_data[`IEN_TX_READY] && !ien_ff[`IEN_TX_READY];
  assign tx_ready_set = tx_cond_rise || (tx_cond && tx_en_rise);
  // resets to the idle level (empty) so reset itself is no false edge
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      tx_cond_ff <= 1'b1;
    else
      tx_cond_ff <= tx_cond;
  end
  // ==========================================
  // sticky sources; a new event wins over the clearing access
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      overrun_ff <= 1'b0;
      line_err_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      xoff_ff <= 1'b0;
      special_ff <= 1'b0;
      flow_ff <= 1'b0;
      wake_ff <= 1'b0;
    end
    else
    begin
      // overrun flags at once on reception
      if (rx_overrun_event)
        overrun_ff <= 1'b1;
      else if (rd_lsr)
        overrun_ff <= 1'b0;
      // parity/framing/break flag when the bad byte at the head is read
      if (rd_rhr && head_err)
        line_err_ff <= 1'b1;
      else if (rd_lsr)
        line_err_ff <= 1'b0;
      // transmit ready: a fresh empty condition, or a 0->1 enable write while the condition holds
      if (tx_ready_set)
        tx_ready_ff <= 1'b1;
      else if (wr_thr || rd_isr)
        tx_ready_ff <= 1'b0;
      // xoff and special character
      if (xoff_detect)
        xoff_ff <= 1'b1;
      else if (rd_isr || xon_detect)
        xoff_ff <= 1'b0;
      if (special_detect)
        special_ff <= 1'b1;
      else if (rd_isr || rx_load)
        special_ff <= 1'b0;
      // flow control change only in auto modes
      // each edge only counts while its own enable bit is set
      if ((rts_rise && auto_rts_enable && ien_ff[`IEN_RTS]) ||
          (cts_rise && auto_cts_enable && ien_ff[`IEN_CTS]))
        flow_ff <= 1'b1;
      else if (rd_msr)
        flow_ff <= 1'b0;
      // wake-up
      if (wake_event)
        wake_ff <= 1'b1;
      else if (rd_isr)
        wake_ff <= 1'b0;
    end
  end
  // ==========================================
  // gated sources
  assign rx_data_src = ien_ff[`IEN_RX_DATA] &&
                       (fifo_enable ? (rx_level >= rx_trig) : !rx_empty);
  assign tmo_src = ien_ff[`IEN_RX_DATA] && tmo_expired;
  assign line_src = ien_ff[`IEN_LINE] && (overrun_ff || line_err_ff);
  assign modem_src = ien_ff[`IEN_MODEM] && (|modem_delta);
  assign tx_src = ien_ff[`IEN_TX_READY] && tx_ready_ff;
  // xoff and flow sources only count while the enhanced bit opens them
  assign xoff_src = enh_enable && ien_ff[`IEN_XOFF] && (xoff_ff || special_ff);
  assign flow_src = enh_enable && (ien_ff[`IEN_RTS] || ien_ff[`IEN_CTS]) && flow_ff;
  // wake-up only while sleep mode is enabled, so no request with all enables low
  assign wake_src = ien_ff[`IEN_SLEEP] && wake_ff;
  // ==========================================
  // priority encoder over pending enabled sources
  always @*
  begin
    nxt_pending = 1'b1;
    if (line_src)
      nxt_code = `CODE_LINE;
    else if (tmo_src)
      nxt_code = `CODE_TIMEOUT;
    else if (rx_data_src)
      nxt_code = `CODE_RX_DATA;
    else if (tx_src)
      nxt_code = `CODE_TX_READY;
    else if (modem_src)
      nxt_code = `CODE_MODEM;
    else if (xoff_src)
      nxt_code = `CODE_XOFF;
    else if (flow_src)
      nxt_code = `CODE_FLOW;
    else
    begin
      nxt_code = `CODE_NONE;
      // wake-up shares the no-interrupt code but still requests service
      nxt_pending = wake_src;
    end
  end
  // ==========================================
  // reported line, time-out or receive data code held while its own source stays pending
  assign code_busy = !code_ff[0] &&
                     ((code_ff == `CODE_LINE && line_src) ||
                      (code_ff == `CODE_TIMEOUT && tmo_src) ||
                      (code_ff == `CODE_RX_DATA && rx_data_src));
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      code_ff <= `CODE_NONE;
      irq_ff <= 1'b0;
    end
    else
    begin
      // only the line source may replace the one still being serviced
      if (!code_busy || nxt_code == `CODE_LINE)
        code_ff <= nxt_code;
      irq_ff <= nxt_pending;
    end
  end
  // ==========================================
  // status byte: fifo mode twice over the six-bit code
  assign status_byte = {fifo_enable, fifo_enable, code_ff};
  // ==========================================
  // read data, registered on the read strobe; a clear on the same read cannot hide the code
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rd_data_ff <= 8'h00;
    else if (rd_strobe)
    begin
      case (addr)
        `ADDR_INTERRUPT_ENABLE: rd_data_ff <= ien_ff;
        `ADDR_INTERRUPT_STATUS: rd_data_ff <= status_byte;
        `ADDR_LINE_STATUS: rd_data_ff <= line_status;
        `ADDR_MODEM_STATUS: rd_data_ff <= {modem_inputs, modem_delta};
        default: rd_data_ff <= 8'h00;
      endcase
    end
  end
endmodule // uart_interrupt_enable_status

// file: uart_interrupt_enable_status_asserts.sv
// concurrent checks on the interrupt enable and status block
`timescale 1ns/100ps
module uart_irq_checker
#(
  parameter LEVEL_W = 5
)
(
  input wire ref_clk,
  input wire reset,
  input wire [2:0] addr,
  input wire rd_strobe,
  input wire wr_strobe,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data_ff,
  input wire [7:0] line_control,
  input wire fifo_enable,
  input wire [1:0] rx_trigger_sel,
  input wire enh_enable,
  input wire [LEVEL_W-1:0] rx_level,
  input wire [LEVEL_W-1:0] tx_level,
  input wire [3:0] modem_delta,
  input wire sleep_enable,
  input wire irq_ff
);
  // ==========================================
  // shadow of the enable register, upper half gated like the real one
  reg [7:0] shadow_ff;
  wire ien_wr = wr_strobe && addr == 3'h1 && !line_control[7];
  wire st_rd = rd_strobe && addr == 3'h2 && line_control != 8'hbf;
  wire [4:0] trig = rx_trigger_sel[1] ? (rx_trigger_sel[0] ? 5'h0e : 5'h08) : (rx_trigger_sel[0] ? 5'h04 : 5'h01);
  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      shadow_ff <= 8'h00;
    else if (ien_wr)
      shadow_ff <= {enh_enable ? wr_data[7:4] : shadow_ff[7:4], wr_data[3:0]};
  end
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // transmit ready: enable set while holding empty, then a quiet bus
  sequence tx_arm_s;
    ien_wr && wr_data[1] && !shadow_ff[1] && !fifo_enable && tx_level == 0;
  endsequence
  sequence tx_quiet_s;
    !fifo_enable && tx_level == 0 && !rd_strobe && !wr_strobe;
  endsequence
  tx_ready_irq_a: assert property (tx_arm_s ##1 tx_quiet_s[*3] |-> irq_ff)
    else $error("transmit ready gave no interrupt");
  ien_readback_a: assert property (rd_strobe && addr == 3'h1 && !line_control[7] |=>
    rd_data_ff[3:0] == $past(shadow_ff[3:0])) else $error("enable read back wrong");
  sleep_follow_a: assert property (ien_wr |=> sleep_enable == shadow_ff[4])
    else $error("sleep enable wrong");
  irq_quiet_a: assert property ((shadow_ff == 8'h00)[*3] |-> !irq_ff)
    else $error("interrupt with all enables low");
  modem_irq_a: assert property ((shadow_ff[3] && modem_delta != 4'h0 && !rd_strobe)[*3] |-> irq_ff)
    else $error("modem delta gave no interrupt");
  rx_trig_irq_a: assert property ((shadow_ff[0] && fifo_enable && rx_level >= trig)[*3] |-> irq_ff)
    else $error("trigger level gave no interrupt");
  fifo_bits_a: assert property (st_rd |=> rd_data_ff[7:6] == {2{$past(fifo_enable)}})
    else $error("status fifo bits wrong");
  status_code_a: assert property (st_rd |=> rd_data_ff[5:0] inside
    {6'h06, 6'h0c, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01}) else $error("illegal status code");
endmodule // uart_irq_checker
bind uart_interrupt_enable_status uart_irq_checker #(.LEVEL_W(LEVEL_W)) u_uart_irq_checker (.ref_clk, .reset,
  .addr, .rd_strobe, .wr_strobe, .wr_data, .rd_data_ff, .line_control, .fifo_enable, .rx_trigger_sel,
  .enh_enable, .rx_level, .tx_level, .modem_delta, .sleep_enable, .irq_ff);

// file: host_bus_model.sv
// host processor model driving the register port
`timescale 1ns/100ps
module host_bus_model
(
  input wire ref_clk,
  output reg [2:0] addr = 3'h0,
  output reg rd_strobe = 1'b0,
  output reg wr_strobe = 1'b0,
  output reg [7:0] wr_data = 8'h00
);
  // ==========================================
  // one-cycle strobes; data inverted after so stale values never pass
  task wr(input [2:0] a, input [7:0] d);
  begin
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge ref_clk);
    wr_strobe <= 1'b0;
    wr_data <= ~d;
    @(posedge ref_clk);
  end
  endtask
  task rd(input [2:0] a);
  begin
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge ref_clk);
    rd_strobe <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
endmodule // host_bus_model

// file: tb_uart_interrupt_enable_status.sv
// self-checking bench for the interrupt enable and status block
`timescale 1ns/100ps
module tb_uart_interrupt_enable_status;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg fifo_enable = 1'b0;
  reg enh_enable = 1'b0;
  reg [1:0] rx_trigger_sel = 2'h0;
  reg [4:0] rx_level = 5'h00;
  reg [3:0] modem_delta = 4'h0;
  reg [5:0] ev = 6'h00;
  reg [3:0] cbits = 4'h0;
  reg tick = 1'b0;
  reg [15:0] lfsr = 16'hd72d;
  reg [15:0] note;
  reg [15:0] exp_q[$];
  reg rd_seen = 1'b0;
  reg [7:0] v;
  reg [4:0] lvl;
  integer errors = 0;
  integer num_checks = 0;
  integer i;
  wire [2:0] addr;
  wire rd_strobe;
  wire wr_strobe;
  wire [7:0] wr_data;
  wire [7:0] rd_data_ff;
  wire sleep_enable;
  wire irq_ff;
  always #12.5 ref_clk = ~ref_clk;
  function [15:0] lfsr_next(input [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // noise on inputs that no check leans on
  always @(posedge ref_clk)
    lfsr <= lfsr_next(lfsr);
  host_bus_model u_host_bus_model (.ref_clk, .addr, .rd_strobe, .wr_strobe, .wr_data);
  uart_interrupt_enable_status u_uart_interrupt_enable_status (.ref_clk, .reset, .addr, .rd_strobe,
    .wr_strobe, .wr_data, .rd_data_ff, .line_control({2'h0, lfsr[15:10]}), .fifo_enable, .rx_trigger_sel,
    .tx_trigger_sel(lfsr[12:11]), .enh_enable, .auto_rts_enable(enh_enable), .auto_cts_enable(enh_enable),
    .rx_level, .rx_load(1'b0), .rx_overrun_event(ev[0]), .rx_head_errors(lfsr[10:8]),
    .rx_fifo_has_error(lfsr[13]), .bit_tick(tick), .char_bits(cbits), .tx_level(rx_level),
    .tx_shift_empty(1'b1), .modem_delta, .modem_inputs(lfsr[3:0]), .rts_rise(ev[4]), .cts_rise(ev[3]),
    .xoff_detect(ev[1]), .xon_detect(1'b0), .special_detect(ev[2]), .wake_event(ev[5]), .sleep_enable,
    .irq_ff);
  task chk(input [7:0] got, input [7:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // a read answers one cycle on; the oldest note is matched to it
  always @(posedge ref_clk)
  begin
    if (rd_seen)
    begin
      note = exp_q.pop_front();
      chk(rd_data_ff & note[15:8], note[7:0] & note[15:8]);
    end
    rd_seen <= rd_strobe;
  end
  task rd_chk(input [2:0] a, input [7:0] e, input [7:0] m);
  begin
    exp_q.push_back({m, e});
    u_host_bus_model.rd(a);
  end
  endtask
  task irq_is(input e);
  begin
    repeat (3) @(posedge ref_clk);
    chk({7'h00, irq_ff}, {7'h00, e});
  end
  endtask
  task finish_test;
  begin
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd_chk(3'h1, 8'h00, 8'hff);
    rd_chk(3'h2, 8'h01, 8'hff);
    irq_is(1'b0);
    v = lfsr[7:0];
    u_host_bus_model.wr(3'h1, v);
    rd_chk(3'h1, {4'h0, v[3:0]}, 8'hff);
    enh_enable <= 1'b1;
    u_host_bus_model.wr(3'h1, v);
    rd_chk(3'h1, v, 8'hff);
    chk({7'h00, sleep_enable}, {7'h00, v[4]});
    rd_chk(3'h2, 8'h00, 8'h00);
    u_host_bus_model.wr(3'h1, 8'h01);
    fifo_enable <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      lvl = (i == 0) ? 5'h01 : (i == 1) ? 5'h04 : (i == 2) ? 5'h08 : 5'h0e;
      rx_trigger_sel <= i[1:0];
      rx_level <= lvl - 5'h01;
      irq_is(1'b0);
      rx_level <= lvl;
      irq_is(1'b1);
      rd_chk(3'h2, 8'hc4, 8'hff);
      rx_level <= lvl - 5'h01;
      irq_is(1'b0);
    end
    // rx data outranks modem; modem stays queued behind it
    u_host_bus_model.wr(3'h1, 8'h0d);
    modem_delta <= 4'h1;
    rx_level <= 5'h0e;
    irq_is(1'b1);
    rd_chk(3'h2, 8'hc4, 8'hff);
    rx_level <= 5'h00;
    irq_is(1'b1);
    rd_chk(3'h2, 8'hc0, 8'hff);
    modem_delta <= 4'h0;
    rd_chk(3'h6, 8'h00, 8'h00);
    irq_is(1'b0);
    fifo_enable <= 1'b0;
    u_host_bus_model.wr(3'h1, 8'h00);
    u_host_bus_model.wr(3'h1, 8'h02);
    irq_is(1'b1);
    rd_chk(3'h2, 8'h02, 8'hff);
    irq_is(1'b0);
    // holding register fills, then empties again
    rx_level <= 5'h01;
    irq_is(1'b0);
    rx_level <= 5'h00;
    irq_is(1'b1);
    u_host_bus_model.wr(3'h0, 8'h55);
    irq_is(1'b0);
    // one event source at a time, each with its own clearing access
    for (i = 0; i < 5; i = i + 1)
    begin
      u_host_bus_model.wr(3'h1, (i == 0) ? 8'h04 : (i < 3) ? 8'h20 : (i == 3) ? 8'h80 : 8'h40);
      ev <= 6'h01 << i;
      @(posedge ref_clk);
      ev <= 6'h00;
      irq_is(1'b1);
      rd_chk(3'h2, (i == 0) ? 8'h06 : (i < 3) ? 8'h10 : 8'h20, 8'hff);
      if (i == 0)
        rd_chk(3'h5, 8'h02, 8'h02);
      if (i > 2)
        rd_chk(3'h6, 8'h00, 8'h00);
      irq_is(1'b0);
    end
    // wake-up reports the no-interrupt code yet requests service
    u_host_bus_model.wr(3'h1, 8'h10);
    ev <= 6'h20;
    @(posedge ref_clk);
    ev <= 6'h00;
    irq_is(1'b1);
    rd_chk(3'h2, 8'h01, 8'hff);
    irq_is(1'b0);
    // time-out: data below trigger, 4 characters plus 12 bit times
    cbits <= lfsr[3:0];
    rx_level <= 5'h01;
    fifo_enable <= 1'b1;
    u_host_bus_model.wr(3'h1, 8'h01);
    tick <= 1'b1;
    repeat ({cbits, 2'h0} + 11) @(posedge ref_clk);
    tick <= 1'b0;
    irq_is(1'b0);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    irq_is(1'b1);
    rd_chk(3'h2, 8'hcc, 8'hff);
    rd_chk(3'h0, 8'h00, 8'h00);
    irq_is(1'b0);
    finish_test;
  end
  // watchdog well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors = errors + 1;
    finish_test;
  end
endmodule // tb_uart_interrupt_enable_status
